/* pkg/status_crc_pkg.sv */
package status_crc_pkg;

  // ==========================================================================
  // Instruction field positions
  localparam int unsigned BW_BIT = 15;
  localparam int unsigned QUAD_HI = 14;
  localparam int unsigned QUAD_LO = 13;
  localparam int unsigned MID_A_HI = 12;
  localparam int unsigned MID_A_LO = 9;
  localparam int unsigned MID_B_HI = 8;
  localparam int unsigned MID_B_LO = 5;
  localparam int unsigned LOW_HI = 4;
  localparam int unsigned LOW_LO = 0;
  localparam int unsigned TEST_HI = 4;
  localparam int unsigned TEST_LO = 1;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] QUAD_RAM = 2'h2;
  localparam logic [1:0] QUAD_NONRAM = 2'h3;
  localparam logic [3:0] MID_STATUS = 4'ha;
  localparam logic [3:0] MID_SET = 4'hb;
  localparam logic [3:0] MID_RESET = 4'ha;
  localparam logic [3:0] MID_SAVE = 4'h7;
  localparam logic [3:0] MID_TEST = 4'h9;
  localparam logic [3:0] MID_NOOP = 4'h8;
  localparam logic [3:0] MID_CRC = 4'h6;
  localparam logic [3:0] MID_CRC_FWD = 4'h3;
  localparam logic [3:0] MID_CRC_REV = 4'h9;

  // Group select codes for set and reset
  localparam logic [4:0] SEL_ARITH = 5'h03;
  localparam logic [4:0] SEL_LINK = 5'h05;
  localparam logic [4:0] SEL_UF1 = 5'h06;
  localparam logic [4:0] SEL_UF2 = 5'h09;
  localparam logic [4:0] SEL_UF3 = 5'h0a;

  // Non-RAM save destinations
  localparam logic [4:0] DEST_RESULT_BUS = 5'h00;
  localparam logic [4:0] DEST_ACCUMULATOR = 5'h01;
  localparam logic [4:0] NOOP_LOW = 5'h00;

  // ==========================================================================
  // Status byte layout
  localparam int unsigned ST_ZERO = 0;
  localparam int unsigned ST_CARRY = 1;
  localparam int unsigned ST_NEG = 2;
  localparam int unsigned ST_OVF = 3;
  localparam int unsigned ST_LINK = 4;
  localparam int unsigned ST_UF1 = 5;
  localparam int unsigned ST_UF2 = 6;
  localparam int unsigned ST_UF3 = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] ACC_RESET = 16'h0000;

  // Condition codes
  localparam logic [3:0] TC_LESS_EQ = 4'h0;
  localparam logic [3:0] TC_N_XOR_V = 4'h1;
  localparam logic [3:0] TC_ZERO = 4'h2;
  localparam logic [3:0] TC_OVF = 4'h3;
  localparam logic [3:0] TC_LOW = 4'h4;
  localparam logic [3:0] TC_CARRY = 4'h5;
  localparam logic [3:0] TC_ZERO_NOCARRY = 4'h6;
  localparam logic [3:0] TC_NEG = 4'h7;
  localparam logic [3:0] TC_LINK = 4'h8;
  localparam logic [3:0] TC_UF1 = 4'h9;
  localparam logic [3:0] TC_UF2 = 4'ha;
  localparam logic [3:0] TC_UF3 = 4'hb;

endpackage

/* rtl/work_reg_file.sv */
`timescale 1ns/1ns
module work_reg_file
(
  // Clock; no reset
  input wire logic i_clk_sys,
  // Read port, registered data
  input wire logic [4:0] i_rd_addr,
  output logic [15:0] o_rd_data,
  // Write port
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [15:0] i_wr_data
);

  logic [15:0] mem_q [32];
  logic [15:0] rd_q;

  // ==========================================================================
  // Storage, no reset so it maps onto a plain RAM
  always_ff @(posedge i_clk_sys)
  begin
    if (i_wr_en)
    begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
    rd_q <= mem_q[i_rd_addr];
  end

  assign o_rd_data = rd_q;

endmodule // work_reg_file

/* rtl/status_crc_condition_unit.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Forward step: Y[i]=((link^reg15)&acc[i])^reg[i-1], bit 0 uses zero.
// - Reverse step: Y[i]=((link^reg0)&acc[i])^reg[i+1], bit 15 uses zero.
// - Step loads link with shifted-out bit; N,Z update; V,C clear.
// - Link is serial input, accumulator is polynomial, register holds sum.
// - Status byte: uf3,uf2,uf1,link,overflow,negative,carry,zero.
// - Set-status decode and group select codes force groups to one.
// - Set-status drives result bus all ones; others keep.
// - Reset-status uses same group codes, forcing groups to zero.
// - Reset-status drives result bus all zeros; others keep.
// - Save writes status to low byte; byte keeps upper of register or accumulator, word and result bus zero it.
// - Save: quad 10 to register; quad 11 to bus or accumulator.
// - Twelve conditions selectable by code on instruction bits 4..1.
// - Test-status instruction changes no flag; result bus undefined.
// - Test bus may pick condition; instruction selection has priority.
// - No-operation changes nothing; result bus undefined.
module status_crc_condition_unit
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Instruction word from the sequencer pipeline
  input wire logic [15:0] i_instr,
  // Test bus ports; output enable is held low, so the unit only listens
  input wire logic [3:0] i_test_bus,
  input wire logic i_test_bus_oe_req,
  output logic [3:0] o_test_bus,
  output logic o_test_bus_oe,
  // Results
  output logic [15:0] o_result,
  output logic o_cond_test_out,
  output logic [7:0] o_condition_status_byte,
  output logic [15:0] o_accumulator
);

  // ==========================================================================
  // Decode
  logic [1:0] quad;
  logic [3:0] mid_a;
  logic [3:0] mid_b;
  logic [4:0] low5;
  logic is_set;
  logic is_reset;
  logic is_save_reg;
  logic is_save_nonreg;
  logic is_test;
  logic is_crc_fwd;
  logic is_crc_rev;

  assign quad = i_instr[status_crc_pkg::QUAD_HI:status_crc_pkg::QUAD_LO];
  assign mid_a = i_instr[status_crc_pkg::MID_A_HI:status_crc_pkg::MID_A_LO];
  assign mid_b = i_instr[status_crc_pkg::MID_B_HI:status_crc_pkg::MID_B_LO];
  assign low5 = i_instr[status_crc_pkg::LOW_HI:status_crc_pkg::LOW_LO];

  assign is_set = !i_instr[status_crc_pkg::BW_BIT]
    && quad == status_crc_pkg::QUAD_NONRAM
    && mid_a == status_crc_pkg::MID_SET
    && mid_b == status_crc_pkg::MID_STATUS;
  assign is_reset = !i_instr[status_crc_pkg::BW_BIT]
    && quad == status_crc_pkg::QUAD_NONRAM
    && mid_a == status_crc_pkg::MID_RESET
    && mid_b == status_crc_pkg::MID_STATUS;
  assign is_save_reg = quad == status_crc_pkg::QUAD_RAM
    && mid_a == status_crc_pkg::MID_SAVE
    && mid_b == status_crc_pkg::MID_STATUS;
  assign is_save_nonreg = quad == status_crc_pkg::QUAD_NONRAM
    && mid_a == status_crc_pkg::MID_SAVE
    && mid_b == status_crc_pkg::MID_STATUS;
  assign is_test = !i_instr[status_crc_pkg::BW_BIT]
    && quad == status_crc_pkg::QUAD_NONRAM
    && mid_a == status_crc_pkg::MID_TEST
    && mid_b == status_crc_pkg::MID_STATUS
    && !low5[0];
  assign is_crc_fwd = i_instr[status_crc_pkg::BW_BIT]
    && quad == status_crc_pkg::QUAD_RAM
    && mid_a == status_crc_pkg::MID_CRC
    && mid_b == status_crc_pkg::MID_CRC_FWD;
  assign is_crc_rev = i_instr[status_crc_pkg::BW_BIT]
    && quad == status_crc_pkg::QUAD_RAM
    && mid_a == status_crc_pkg::MID_CRC
    && mid_b == status_crc_pkg::MID_CRC_REV;

  // Group mask, shared by set and reset
  function automatic logic [7:0] group_mask(input logic [4:0] sel);
    logic [7:0] m;
    m = 8'h00;
    unique case (sel)
      status_crc_pkg::SEL_ARITH: m = 8'h0f;
      status_crc_pkg::SEL_LINK: m = 8'h01 << status_crc_pkg::ST_LINK;
      status_crc_pkg::SEL_UF1: m = 8'h01 << status_crc_pkg::ST_UF1;
      status_crc_pkg::SEL_UF2: m = 8'h01 << status_crc_pkg::ST_UF2;
      status_crc_pkg::SEL_UF3: m = 8'h01 << status_crc_pkg::ST_UF3;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Condition select
  function automatic logic cond_of(input logic [3:0] c, input logic [7:0] s);
    logic n;
    logic v;
    logic z;
    logic k;
    n = s[status_crc_pkg::ST_NEG];
    v = s[status_crc_pkg::ST_OVF];
    z = s[status_crc_pkg::ST_ZERO];
    k = s[status_crc_pkg::ST_CARRY];
    unique case (c)
      status_crc_pkg::TC_LESS_EQ: cond_of = (n ^ v) | z;
      status_crc_pkg::TC_N_XOR_V: cond_of = n ^ v;
      status_crc_pkg::TC_ZERO: cond_of = z;
      status_crc_pkg::TC_OVF: cond_of = v;
      status_crc_pkg::TC_LOW: cond_of = 1'b0;
      status_crc_pkg::TC_CARRY: cond_of = k;
      status_crc_pkg::TC_ZERO_NOCARRY: cond_of = z | !k;
      status_crc_pkg::TC_NEG: cond_of = n;
      status_crc_pkg::TC_LINK: cond_of = s[status_crc_pkg::ST_LINK];
      status_crc_pkg::TC_UF1: cond_of = s[status_crc_pkg::ST_UF1];
      status_crc_pkg::TC_UF2: cond_of = s[status_crc_pkg::ST_UF2];
      status_crc_pkg::TC_UF3: cond_of = s[status_crc_pkg::ST_UF3];
      default: cond_of = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // Working registers; read data registered, so a CRC uses a two-cycle step
  logic [15:0] rd_data;
  logic wr_en_q;
  logic wr_en_d;
  logic [4:0] wr_addr_q;
  logic [4:0] wr_addr_d;
  logic [15:0] wr_data_q;
  logic [15:0] wr_data_d;

  work_reg_file u_regs
  (
    .i_clk_sys(i_clk_sys),
    .i_rd_addr(low5),
    .o_rd_data(rd_data),
    .i_wr_en(wr_en_q),
    .i_wr_addr(wr_addr_q),
    .i_wr_data(wr_data_q)
  );

  // Bypass so a read right after a write sees the new word
  logic [15:0] reg_val;
  logic bypass_q;
  assign reg_val = bypass_q ? wr_data_q : rd_data;

  // ==========================================================================
  // Sequencing: CRC and register save wait one cycle for read data
  typedef enum logic [0:0] {ST_ISSUE = 1'b0, ST_EXEC = 1'b1} phase_e;
  phase_e phase_q;
  phase_e phase_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [15:0] acc_q;
  logic [15:0] acc_d;
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic cond_q;
  logic cond_d;
  logic [15:0] crc_y;
  logic link_in;
  logic fb;
  logic needs_read;

  assign needs_read = is_crc_fwd || is_crc_rev || is_save_reg;
  assign link_in = status_q[status_crc_pkg::ST_LINK];

  always_comb
  begin
    fb = 1'b0;
    crc_y = 16'h0000;
    if (is_crc_fwd)
    begin
      fb = link_in ^ reg_val[15];
      crc_y = ({16{fb}} & acc_q) ^ {reg_val[14:0], 1'b0};
    end
    else
    begin
      fb = link_in ^ reg_val[0];
      crc_y = ({16{fb}} & acc_q) ^ {1'b0, reg_val[15:1]};
    end
  end

  always_comb
  begin
    phase_d = ST_ISSUE;
    status_d = status_q;
    acc_d = acc_q;
    result_d = result_q;
    wr_en_d = 1'b0;
    wr_addr_d = low5;
    wr_data_d = wr_data_q;
    // Instruction code wins over the test bus
    if (is_test)
    begin
      cond_d = cond_of(
        i_instr[status_crc_pkg::TEST_HI:status_crc_pkg::TEST_LO],
        status_q);
    end
    else
    begin
      cond_d = cond_of(i_test_bus, status_q);
    end
    if (is_set)
    begin
      status_d = status_q | group_mask(low5);
      result_d = 16'hffff;
    end
    else if (is_reset)
    begin
      status_d = status_q & ~group_mask(low5);
      result_d = 16'h0000;
    end
    else if (is_save_nonreg)
    begin
      result_d = {8'h00, status_q};
      if (low5 == status_crc_pkg::DEST_ACCUMULATOR)
      begin
        acc_d = i_instr[status_crc_pkg::BW_BIT] ? {8'h00, status_q}
          : {acc_q[15:8], status_q};
      end
    end
    else if (needs_read && phase_q == ST_ISSUE)
    begin
      phase_d = ST_EXEC;
    end
    else if (needs_read)
    begin
      wr_en_d = 1'b1;
      if (is_save_reg)
      begin
        result_d = {8'h00, status_q};
        wr_data_d = i_instr[status_crc_pkg::BW_BIT] ? {8'h00, status_q}
          : {reg_val[15:8], status_q};
      end
      else
      begin
        result_d = crc_y;
        wr_data_d = crc_y;
        status_d[status_crc_pkg::ST_LINK] = is_crc_fwd ? reg_val[15]
          : reg_val[0];
        status_d[status_crc_pkg::ST_NEG] = crc_y[15];
        status_d[status_crc_pkg::ST_ZERO] = crc_y == 16'h0000;
        status_d[status_crc_pkg::ST_OVF] = 1'b0;
        status_d[status_crc_pkg::ST_CARRY] = 1'b0;
      end
    end
    // Test and no-op fall through: only the condition output changes
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      phase_q <= ST_ISSUE;
      status_q <= status_crc_pkg::STATUS_RESET;
      acc_q <= status_crc_pkg::ACC_RESET;
      result_q <= 16'h0000;
      cond_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 5'h00;
      wr_data_q <= 16'h0000;
      bypass_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      status_q <= status_d;
      acc_q <= acc_d;
      result_q <= result_d;
      cond_q <= cond_d;
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      bypass_q <= wr_en_q && wr_addr_q == low5;
    end
  end

  // Test bus is input only here; the sequencer drives the code
  assign o_test_bus = 4'h0;
  assign o_test_bus_oe = 1'b0;
  assign o_result = result_q;
  assign o_cond_test_out = cond_q;
  assign o_condition_status_byte = status_q;
  assign o_accumulator = acc_q;

endmodule // status_crc_condition_unit

/* bench/status_crc_condition_unit_props.sv */
`timescale 1ns/1ns
// =====
// Checker on the unit ports
module status_crc_checker
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Watched ports
  input wire logic [15:0] i_instr,
  input wire logic [15:0] o_result,
  input wire logic o_cond_test_out,
  input wire logic [7:0] o_condition_status_byte,
  input wire logic [15:0] o_accumulator
);
  logic [7:0] st;
  logic crc;
  assign st = o_condition_status_byte;
  // Either step direction, register field ignored
  assign crc = i_instr[15:5] == 11'h663 || i_instr[15:5] == 11'h669;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // =====
  // Properties
  property p_set;
    i_instr == 16'h7743 |=> o_result == 16'hffff && st[3:0] == 4'hf
      && st[7:4] == $past(st[7:4]);
  endproperty
  a_set: assert property (p_set)
    else $error("set group");
  property p_clr;
    i_instr == 16'h7543 |=> o_result == 16'h0000 && st[3:0] == 4'h0
      && st[7:4] == $past(st[7:4]);
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear group");
  property p_link;
    i_instr == 16'h7745 |=> st == ($past(st) | 8'h10);
  endproperty
  a_link: assert property (p_link)
    else $error("set link");
  property p_idle;
    i_instr == 16'h7140 |=> $stable(st) && $stable(o_accumulator);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle changed state");
  property p_test;
    i_instr[15:5] == 11'h39a && !i_instr[0] |=> $stable(st);
  endproperty
  a_test: assert property (p_test)
    else $error("test changed status");
  property p_zero;
    i_instr == 16'h7344 |=> o_cond_test_out == $past(st[0]);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero condition");
  property p_save;
    i_instr == 16'hef41 |=> o_accumulator == {8'h00, $past(st)};
  endproperty
  a_save: assert property (p_save)
    else $error("save to accumulator");
  property p_step;
    !crc ##1 crc [*2] |=> st[3] == 1'b0 && st[1] == 1'b0
      && st[2] == o_result[15] && st[0] == (o_result == 16'h0000);
  endproperty
  a_step: assert property (p_step)
    else $error("step flags");
  c_step: cover property (!crc ##1 crc [*2]);
  c_test: cover property (i_instr[15:5] == 11'h39a);
  c_save: cover property (i_instr == 16'hef41);
endmodule // status_crc_checker

bind status_crc_condition_unit status_crc_checker u_chk
(
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_instr(i_instr),
  .o_result(o_result),
  .o_cond_test_out(o_cond_test_out),
  .o_condition_status_byte(o_condition_status_byte),
  .o_accumulator(o_accumulator)
);

/* bench/sequencer_model.sv */
`timescale 1ns/1ns
// =====
// Sequencer side of the unit
module sequencer_model
(
  // Clock
  input wire logic i_clk_sys,
  // Toward the unit
  output logic [15:0] o_instr,
  output logic [3:0] o_test_code
);
  initial
  begin
    o_instr = 16'h7140;
    o_test_code = 4'h4;
  end
  // Word held n edges; two-cycle ops need n of 2
  task automatic issue(input logic [15:0] v, input int n);
    o_instr = v;
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Bus code only counts while no test word is present
  task automatic bus(input logic [3:0] c);
    o_test_code = c;
  endtask
endmodule // sequencer_model

/* bench/test_status_crc_condition_unit.sv */
`timescale 1ns/1ns
// =====
// Bench for the status, step and condition unit
module test_status_crc_condition_unit;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] instr, result, acc, ea;
  logic [3:0] code, tbus, t_out;
  logic t_oe, cond;
  logic [7:0] st;
  logic [7:0] es = 8'h00;
  logic [4:0] sel [5] = '{5'h03, 5'h05, 5'h06, 5'h09, 5'h0a};
  logic [7:0] grp [5] = '{8'h0f, 8'h10, 8'h20, 8'h40, 8'h80};
  int errors = 0;
  int check_count = 0;

  always #10 i_clk_sys = ~i_clk_sys;
  // Unit only listens; resolve the wire all the same
  assign tbus = t_oe ? t_out : code;

  sequencer_model seq
  (
    .i_clk_sys(i_clk_sys),
    .o_instr(instr),
    .o_test_code(code)
  );
  status_crc_condition_unit DUT
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_instr(instr),
    .i_test_bus(tbus),
    .i_test_bus_oe_req(1'b0),
    .o_test_bus(t_out),
    .o_test_bus_oe(t_oe),
    .o_result(result),
    .o_cond_test_out(cond),
    .o_condition_status_byte(st),
    .o_accumulator(acc)
  );

  // =====
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  function automatic logic cx(input logic [3:0] c, input logic [7:0] s);
    logic [11:0] v;
    v = {s[7:4], s[2], s[0] | ~s[1], s[1], 1'b0, s[3], s[0], s[2] ^ s[3],
      (s[2] ^ s[3]) | s[0]};
    return v[c];
  endfunction
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // =====
  // Scenarios
  task automatic t_groups;
    for (int i = 0; i < 5; i++)
    begin
      seq.issue({11'h3ba, sel[i]}, 1);
      es = es | grp[i];
      chk(result, 16'hffff);
      chk(16'(st), 16'(es));
    end
    // Unused select code must leave the byte alone
    seq.issue(16'h755f, 1);
    chk(16'(st), 16'(es));
    for (int i = 4; i >= 0; i--)
    begin
      seq.issue({11'h3aa, sel[i]}, 1);
      es = es & ~grp[i];
      chk(result, 16'h0000);
      chk(16'(st), 16'(es));
    end
  endtask
  task automatic t_cond;
    for (int c = 0; c < 12; c++)
    begin
      seq.bus(4'(c));
      seq.issue(16'h7140, 1);
      chk(16'(cond), 16'(cx(4'(c), es)));
      seq.bus(4'(11 - c));
      seq.issue({11'h39a, 4'(c), 1'b0}, 1);
      chk(16'(cond), 16'(cx(4'(c), es)));
      chk(16'(st), 16'(es));
    end
  endtask
  task automatic t_save;
    seq.issue(16'h6f40, 1);
    chk(result, 16'(es));
    seq.issue(16'hef41, 1);
    ea = 16'(es);
    chk(acc, ea);
    chk(16'(st), 16'(es));
  endtask
  // Chained steps: each one reads the sum the last one wrote
  task automatic t_crc;
    logic [15:0] r, y;
    logic f, lk;
    seq.issue(16'hcf45, 2);
    r = 16'(es);
    for (int i = 0; i < 12; i++)
    begin
      if (i < 8)
      begin
        f = es[4] ^ r[15];
        lk = r[15];
        y = ({16{f}} & ea) ^ {r[14:0], 1'b0};
        seq.issue(16'hcc65, 2);
        chk(result, y);
      end
      else
      begin
        f = es[4] ^ r[0];
        lk = r[0];
        y = ({16{f}} & ea) ^ {1'b0, r[15:1]};
        seq.issue(16'hcd25, 2);
        chk(result, y);
      end
      es = {es[7:5], lk, 1'b0, y[15], 1'b0, y == 16'h0000};
      r = y;
      chk(16'(st), 16'(es));
    end
    // Byte save keeps the upper half; the next step reads it back
    seq.issue(16'h4f45, 2);
    chk(result, 16'(es));
    chk(16'(st), 16'(es));
    r = {r[15:8], es};
    f = es[4] ^ r[15];
    lk = r[15];
    y = ({16{f}} & ea) ^ {r[14:0], 1'b0};
    seq.issue(16'hcc65, 2);
    chk(result, y);
    es = {es[7:5], lk, 1'b0, y[15], 1'b0, y == 16'h0000};
    chk(16'(st), 16'(es));
  endtask
  // Reset in mid-run clears the state, then conditions follow again
  task automatic t_reset;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    es = 8'h00;
    chk(16'(st), 16'h0000);
    chk(acc, 16'h0000);
    chk(result, 16'h0000);
    t_cond;
  endtask

  // Run takes about 150 cycles; far beyond that is a hang
  initial
  begin
    #100000;
    errors++;
    end_of_test;
  end

  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    chk(16'(st), 16'h0000);
    chk(acc, 16'h0000);
    chk({11'h000, t_oe, t_out}, 16'h0000);
    t_groups;
    t_cond;
    seq.issue(16'h7749, 1);
    seq.issue(16'h7745, 1);
    es = 8'h50;
    t_cond;
    t_save;
    t_crc;
    t_cond;
    t_reset;
    end_of_test;
  end
endmodule // test_status_crc_condition_unit
